// ### design/tccpc_top.sv
// timer capture/compare pin control: register port, three b channels, cascade
`timescale 1ns/10ps
module tccpc_top #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // counters and cascade sources
  input wire logic [DATA_W-1:0] CHAN1_COUNTER,
  input wire logic [DATA_W-1:0] CHAN2_COUNTER,
  input wire logic [DATA_W-1:0] CHAN3_COUNTER,
  input wire logic CHAN1_COUNT_TICK,
  input wire logic CHAN4_COUNT_TICK,
  input wire logic CHAN0_REG_C_EVENT,
  input wire logic CHAN0_REG_D_IO_EVENT,
  // channel 0 cascade and register d qualifications
  output logic CHAN0_CASC_CAPTURE,
  output logic CHAN0_REG_D_ENABLE,
  // pins
  input wire logic CHAN1_B_PIN_IN,
  output logic CHAN1_B_PIN_OUT,
  output logic CHAN1_B_PIN_OE,
  input wire logic CHAN2_B_PIN_IN,
  output logic CHAN2_B_PIN_OUT,
  output logic CHAN2_B_PIN_OE,
  input wire logic CHAN3_B_PIN_IN,
  output logic CHAN3_B_PIN_OUT,
  output logic CHAN3_B_PIN_OE,
  // interrupt
  output logic IRQ
);
  localparam int NCH = 3;

  logic [7:0] ioctl_q [NCH];
  logic [7:0] casc_q;
  logic [2*NCH-1:0] status_q;
  logic [2*NCH-1:0] status_d;
  logic [2*NCH-1:0] mask_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [NCH-1:0] pin_meta_q;
  logic [NCH-1:0] pin_sync_q;
  logic [NCH-1:0] pin_in;
  logic [NCH-1:0] pin_out;
  logic [NCH-1:0] pin_oe;
  logic [NCH-1:0] ioctl_wr;
  logic [NCH-1:0] reg_b_wr;
  logic [NCH-1:0] casc_event;
  logic [NCH-1:0] casc_valid;
  logic [NCH-1:0] cmp_evt;
  logic [NCH-1:0] cap_evt;
  logic [DATA_W-1:0] counter [NCH];
  logic [DATA_W-1:0] reg_b [NCH];
  logic [2:0] psc1;
  logic [2:0] psc4;
  logic wr_casc;
  logic wr_status;
  logic wr_mask;
  logic [2*NCH-1:0] events;

  function automatic logic [15:0] zext8(input logic [7:0] v);
    zext8 = {8'h00, v};
  endfunction

  function automatic logic [15:0] zextw(input logic [DATA_W-1:0] v);
    logic [15:0] r;
    r = '0;
    r[DATA_W-1:0] = v;
    zextw = r;
  endfunction

  assign pin_in = {CHAN3_B_PIN_IN, CHAN2_B_PIN_IN, CHAN1_B_PIN_IN};
  assign counter[0] = CHAN1_COUNTER;
  assign counter[1] = CHAN2_COUNTER;
  assign counter[2] = CHAN3_COUNTER;

  // write decode
  assign ioctl_wr[0] = REG_WR && (REG_ADDR == tccpc_pkg::ADDR_CH1_IOCTL);
  assign ioctl_wr[1] = REG_WR && (REG_ADDR == tccpc_pkg::ADDR_CH2_IOCTL);
  assign ioctl_wr[2] = REG_WR && (REG_ADDR == tccpc_pkg::ADDR_CH3_IOCTL);
  assign reg_b_wr[0] = REG_WR && (REG_ADDR == tccpc_pkg::ADDR_CH1_REG_B);
  assign reg_b_wr[1] = REG_WR && (REG_ADDR == tccpc_pkg::ADDR_CH2_REG_B);
  assign reg_b_wr[2] = REG_WR && (REG_ADDR == tccpc_pkg::ADDR_CH3_REG_B);
  assign wr_casc = REG_WR && (REG_ADDR == tccpc_pkg::ADDR_CASC_CTRL);
  assign wr_status = REG_WR && (REG_ADDR == tccpc_pkg::ADDR_INT_STATUS);
  assign wr_mask = REG_WR && (REG_ADDR == tccpc_pkg::ADDR_INT_MASK);

  // cascade sources and their qualification
  assign psc1 = casc_q[tccpc_pkg::CASC_PSC1_LO +: 3];
  assign psc4 = casc_q[tccpc_pkg::CASC_PSC4_LO +: 3];
  assign casc_event = {CHAN4_COUNT_TICK, 1'b0, CHAN0_REG_C_EVENT};
  // undivided count clock leaves no room for a capture, so it is blocked
  assign casc_valid = {psc4 != tccpc_pkg::PSC_UNDIVIDED, 1'b0, 1'b1};
  assign CHAN0_CASC_CAPTURE = CHAN1_COUNT_TICK && (psc1 != tccpc_pkg::PSC_UNDIVIDED);
  assign CHAN0_REG_D_ENABLE = CHAN0_REG_D_IO_EVENT &&
                              !casc_q[tccpc_pkg::CASC_CH0_BUF_D];

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      tccpc_channel #(
        .DATA_W(DATA_W),
        .BIT6_IGNORED_IN_CAPTURE(g == 1)
      ) u_ch (
        .clk(SYS_CLK),
        .rst(RST),
        .fsel(ioctl_q[g][tccpc_pkg::FSEL_HI:tccpc_pkg::FSEL_LO]),
        .fsel_wr(ioctl_wr[g]),
        .fsel_init(REG_WDATA[tccpc_pkg::FSEL_INIT_BIT]),
        .casc_event(casc_event[g]),
        .casc_valid(casc_valid[g]),
        .counter(counter[g]),
        .pin_in_sync(pin_sync_q[g]),
        .reg_b_wr(reg_b_wr[g]),
        .reg_b_wdata(REG_WDATA[DATA_W-1:0]),
        .reg_b(reg_b[g]),
        .pin_out(pin_out[g]),
        .pin_oe(pin_oe[g]),
        .compare_evt(cmp_evt[g]),
        .capture_evt(cap_evt[g])
      );
    end
  endgenerate

  // status bits: compare in low half, capture in high half
  assign events = {cap_evt, cmp_evt};
  // a new event wins over a write-one clear in the same cycle
  assign status_d = (status_q & ~(wr_status ? REG_WDATA[2*NCH-1:0] : '0)) | events;

  always_comb begin
    case (REG_ADDR)
      tccpc_pkg::ADDR_CH1_IOCTL: rdata_d = zext8(ioctl_q[0]);
      tccpc_pkg::ADDR_CH2_IOCTL: rdata_d = zext8(ioctl_q[1]);
      tccpc_pkg::ADDR_CH3_IOCTL: rdata_d = zext8(ioctl_q[2]);
      tccpc_pkg::ADDR_CASC_CTRL: rdata_d = zext8(casc_q);
      tccpc_pkg::ADDR_INT_STATUS: rdata_d = zext8({2'b00, status_q});
      tccpc_pkg::ADDR_INT_MASK: rdata_d = zext8({2'b00, mask_q});
      tccpc_pkg::ADDR_PIN_STATE: rdata_d = zext8({2'b00, pin_oe, pin_out});
      tccpc_pkg::ADDR_CH1_REG_B: rdata_d = zextw(reg_b[0]);
      tccpc_pkg::ADDR_CH2_REG_B: rdata_d = zextw(reg_b[1]);
      tccpc_pkg::ADDR_CH3_REG_B: rdata_d = zextw(reg_b[2]);
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      for (int i = 0; i < NCH; i++) begin
        ioctl_q[i] <= tccpc_pkg::IOCTL_RESET;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (ioctl_wr[i]) begin
          ioctl_q[i] <= REG_WDATA[7:0];
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      casc_q <= tccpc_pkg::CASC_RESET;
      status_q <= '0;
      mask_q <= '0;
      rdata_q <= 16'h0000;
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      if (wr_casc) begin
        casc_q <= REG_WDATA[7:0];
      end
      if (wr_mask) begin
        mask_q <= REG_WDATA[2*NCH-1:0];
      end
      status_q <= status_d;
      rdata_q <= REG_RD ? rdata_d : 16'h0000;
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign REG_RDATA = rdata_q;
  assign CHAN1_B_PIN_OUT = pin_out[0];
  assign CHAN1_B_PIN_OE = pin_oe[0];
  assign CHAN2_B_PIN_OUT = pin_out[1];
  assign CHAN2_B_PIN_OE = pin_oe[1];
  assign CHAN3_B_PIN_OUT = pin_out[2];
  assign CHAN3_B_PIN_OE = pin_oe[2];
  assign IRQ = |(status_q & mask_q);
endmodule

// ### design/tccpc_pkg.sv
// constants for the timer capture/compare pin control block
package tccpc_pkg;
  localparam int DATA_W = 16;
  localparam int REG_W = 8;
  localparam int ADDR_W = 4;
  // register indices on the plain register port
  localparam logic [3:0] ADDR_CH1_IOCTL = 4'h0;
  localparam logic [3:0] ADDR_CH2_IOCTL = 4'h1;
  localparam logic [3:0] ADDR_CH3_IOCTL = 4'h2;
  localparam logic [3:0] ADDR_CASC_CTRL = 4'h3;
  localparam logic [3:0] ADDR_INT_STATUS = 4'h4;
  localparam logic [3:0] ADDR_INT_MASK = 4'h5;
  localparam logic [3:0] ADDR_PIN_STATE = 4'h6;
  localparam logic [3:0] ADDR_CH1_REG_B = 4'h8;
  localparam logic [3:0] ADDR_CH2_REG_B = 4'h9;
  localparam logic [3:0] ADDR_CH3_REG_B = 4'ha;
  // function-select field position
  localparam int FSEL_HI = 7;
  localparam int FSEL_LO = 4;
  localparam int FSEL_INIT_BIT = 6;
  // cascade control register bits
  localparam int CASC_CH0_BUF_D = 0;
  localparam int CASC_PSC1_LO = 1;
  localparam int CASC_PSC4_LO = 4;
  localparam logic [2:0] PSC_UNDIVIDED = 3'h0;
  localparam logic [7:0] IOCTL_RESET = 8'h00;
  localparam logic [7:0] CASC_RESET = 8'h00;
  // pin actions in compare mode
  typedef enum logic [1:0] {
    TCC_ACT_NONE,
    TCC_ACT_LOW,
    TCC_ACT_HIGH,
    TCC_ACT_TOGGLE
  } tcc_act_type;
  // capture edge choice
  typedef enum logic [1:0] {
    TCC_EDGE_RISE,
    TCC_EDGE_FALL,
    TCC_EDGE_BOTH,
    TCC_EDGE_CASC
  } tcc_edge_type;
endpackage

// ### design/tccpc_channel.sv
// one channel: register b, compare pin output and capture logic
`timescale 1ns/10ps
module tccpc_channel #(
  parameter int DATA_W = 16,
  parameter bit BIT6_IGNORED_IN_CAPTURE = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic [3:0] fsel,
  input wire logic fsel_wr,
  input wire logic fsel_init,
  input wire logic casc_event,
  input wire logic casc_valid,
  input wire logic [DATA_W-1:0] counter,
  input wire logic pin_in_sync,
  // software write of register b
  input wire logic reg_b_wr,
  input wire logic [DATA_W-1:0] reg_b_wdata,
  // results
  output logic [DATA_W-1:0] reg_b,
  output logic pin_out,
  output logic pin_oe,
  output logic compare_evt,
  output logic capture_evt
);
  logic [DATA_W-1:0] reg_b_q;
  logic [DATA_W-1:0] reg_b_d;
  logic pin_q;
  logic pin_d;
  logic pin_prev_q;
  logic capture_mode;
  logic [1:0] sel_low;
  logic match;
  logic rise;
  logic fall;
  logic casc_sel;
  tccpc_pkg::tcc_act_type act;
  tccpc_pkg::tcc_edge_type edge_sel;

  // field top bit picks capture, else compare
  assign capture_mode = fsel[3];
  assign sel_low = fsel[1:0];
  assign act = tccpc_pkg::tcc_act_type'(sel_low);
  // channel 2 has no cascade source, so bit 6 is don't care there
  assign casc_sel = fsel[2] && !BIT6_IGNORED_IN_CAPTURE;
  assign edge_sel = casc_sel ? tccpc_pkg::TCC_EDGE_CASC :
                    sel_low[1] ? tccpc_pkg::TCC_EDGE_BOTH :
                    sel_low[0] ? tccpc_pkg::TCC_EDGE_FALL :
                    tccpc_pkg::TCC_EDGE_RISE;
  assign match = !capture_mode && (counter == reg_b_q);
  assign rise = pin_in_sync && !pin_prev_q;
  assign fall = !pin_in_sync && pin_prev_q;

  always_comb begin
    capture_evt = 1'b0;
    if (capture_mode) begin
      case (edge_sel)
        tccpc_pkg::TCC_EDGE_RISE: capture_evt = rise;
        tccpc_pkg::TCC_EDGE_FALL: capture_evt = fall;
        tccpc_pkg::TCC_EDGE_BOTH: capture_evt = rise || fall;
        tccpc_pkg::TCC_EDGE_CASC: capture_evt = casc_event && casc_valid;
        default: capture_evt = 1'b0;
      endcase
    end
  end

  assign compare_evt = match && (act != tccpc_pkg::TCC_ACT_NONE);

  always_comb begin
    pin_d = pin_q;
    if (fsel_wr) begin
      // level comes from the write itself, the field register still holds the old one
      pin_d = fsel_init;
    end else if (compare_evt) begin
      case (act)
        tccpc_pkg::TCC_ACT_LOW: pin_d = 1'b0;
        tccpc_pkg::TCC_ACT_HIGH: pin_d = 1'b1;
        tccpc_pkg::TCC_ACT_TOGGLE: pin_d = !pin_q;
        default: pin_d = pin_q;
      endcase
    end
  end

  // capture wins over a software write in the same cycle
  assign reg_b_d = capture_evt ? counter : (reg_b_wr ? reg_b_wdata : reg_b_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_b_q <= '0;
      pin_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      reg_b_q <= reg_b_d;
      pin_q <= pin_d;
      pin_prev_q <= pin_in_sync;
    end
  end

  assign reg_b = reg_b_q;
  assign pin_out = pin_q;
  // low bits 00 disable the pin output whatever bit 6 holds
  assign pin_oe = !capture_mode && (sel_low != 2'b00);
endmodule

// ### bench/tccpc_pins.sv
// model of the outside drivers on the three b pins
`timescale 1ns/10ps
module tccpc_pins (
  // levels from the block
  input wire logic [2:0] out,
  input wire logic [2:0] oe,
  // levels the far side drives
  input wire logic [2:0] ext,
  output logic [2:0] pin
);
  // a driven pin follows the block, a released one the far side
  assign pin = (oe & out) | (~oe & ext);
endmodule

// ### bench/tccpc_checker.sv
// assertions on the top-level ports of the pin control block
`timescale 1ns/10ps
module tccpc_checker #(
  parameter int DATA_W = 16
) (
  // clock, reset and register port
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  // channel 1 and channel 0 signals
  input wire logic [DATA_W-1:0] CHAN1_COUNTER,
  input wire logic CHAN1_COUNT_TICK,
  input wire logic CHAN0_REG_D_IO_EVENT,
  input wire logic CHAN0_CASC_CAPTURE,
  input wire logic CHAN0_REG_D_ENABLE,
  input wire logic CHAN1_B_PIN_OUT,
  input wire logic CHAN1_B_PIN_OE
);
  logic [7:0] io_q;
  logic [7:0] casc_q;
  logic [DATA_W-1:0] rb_q;
  wire [3:0] fs = io_q[7:4];
  wire wr_io = REG_WR && REG_ADDR == tccpc_pkg::ADDR_CH1_IOCTL;
  wire wr_cc = REG_WR && REG_ADDR == tccpc_pkg::ADDR_CASC_CTRL;
  wire wr_rb = REG_WR && REG_ADDR == tccpc_pkg::ADDR_CH1_REG_B;
  // register b mirror is only trusted in compare mode, where nothing captures
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      io_q <= 8'h00;
      casc_q <= 8'h00;
      rb_q <= '0;
    end else begin
      if (wr_io) io_q <= REG_WDATA[7:0];
      if (wr_cc) casc_q <= REG_WDATA[7:0];
      if (wr_rb) rb_q <= REG_WDATA[DATA_W-1:0];
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence s_hit(logic [1:0] act);
    !fs[3] && fs[1:0] == act && CHAN1_COUNTER == rb_q && !REG_WR;
  endsequence
  casc_gate_a: assert property (CHAN0_CASC_CAPTURE == (CHAN1_COUNT_TICK && casc_q[3:1] != 3'h0))
    else $error("cascade capture gating wrong");
  dbuf_gate_a: assert property (CHAN0_REG_D_ENABLE == (CHAN0_REG_D_IO_EVENT && !casc_q[0]))
    else $error("register d buffer gating wrong");
  pin_role_a: assert property (CHAN1_B_PIN_OE == (!fs[3] && fs[1:0] != 2'h0))
    else $error("pin enable does not follow the select field");
  init_level_a: assert property (wr_io && !REG_WDATA[7] |=> CHAN1_B_PIN_OUT == $past(REG_WDATA[6]))
    else $error("initial pin level wrong");
  match_low_a: assert property (s_hit(2'h1) |=> !CHAN1_B_PIN_OUT)
    else $error("pin not low after match");
  match_high_a: assert property (s_hit(2'h2) |=> CHAN1_B_PIN_OUT)
    else $error("pin not high after match");
  match_toggle_a: assert property (s_hit(2'h3) |=> CHAN1_B_PIN_OUT != $past(CHAN1_B_PIN_OUT))
    else $error("pin not toggled after match");
  rdata_idle_a: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
    else $error("read data outside the read answer");
endmodule
bind tccpc_top tccpc_checker #(.DATA_W(DATA_W)) tccpc_checker_i (.SYS_CLK(SYS_CLK), .RST(RST),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .CHAN1_COUNTER(CHAN1_COUNTER), .CHAN1_COUNT_TICK(CHAN1_COUNT_TICK),
  .CHAN0_REG_D_IO_EVENT(CHAN0_REG_D_IO_EVENT), .CHAN0_CASC_CAPTURE(CHAN0_CASC_CAPTURE),
  .CHAN0_REG_D_ENABLE(CHAN0_REG_D_ENABLE), .CHAN1_B_PIN_OUT(CHAN1_B_PIN_OUT),
  .CHAN1_B_PIN_OE(CHAN1_B_PIN_OE));

// ### bench/tccpc_top_tb.sv
// testbench: register-driven compare, capture and cascade tests
`timescale 1ns/10ps
module tccpc_top_tb;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic [3:0] REG_ADDR = 4'h0;
  logic [15:0] REG_WDATA = 16'h0000;
  logic [15:0] cnt = 16'h0000;
  logic REG_WR = 1'b0;
  logic REG_RD = 1'b0;
  logic [3:0] evs = 4'h0;
  logic [2:0] ext = 3'h0;
  wire [15:0] REG_RDATA;
  wire [2:0] pout, poe, pin;
  wire casc0, den, IRQ;
  int err_count = 0;
  int checks = 0;
  int b, o, f;
  logic [15:0] e;
  tccpc_top tccpc_top_i (.SYS_CLK(SYS_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .CHAN1_COUNTER(cnt), .CHAN2_COUNTER(cnt), .CHAN3_COUNTER(cnt),
    .CHAN1_COUNT_TICK(evs[0]), .CHAN4_COUNT_TICK(evs[1]), .CHAN0_REG_C_EVENT(evs[2]),
    .CHAN0_REG_D_IO_EVENT(evs[3]), .CHAN0_CASC_CAPTURE(casc0), .CHAN0_REG_D_ENABLE(den),
    .CHAN1_B_PIN_IN(pin[0]), .CHAN1_B_PIN_OUT(pout[0]), .CHAN1_B_PIN_OE(poe[0]),
    .CHAN2_B_PIN_IN(pin[1]), .CHAN2_B_PIN_OUT(pout[1]), .CHAN2_B_PIN_OE(poe[1]),
    .CHAN3_B_PIN_IN(pin[2]), .CHAN3_B_PIN_OUT(pout[2]), .CHAN3_B_PIN_OE(poe[2]), .IRQ(IRQ));
  tccpc_pins tccpc_pins_i (.out(pout), .oe(poe), .ext(ext), .pin(pin));
  initial begin
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  task automatic chk(string n, logic [15:0] s, logic [15:0] x);
    checks++;
    if (s !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(int a, logic [15:0] d);
    @(posedge SYS_CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a[3:0];
    REG_WDATA <= d;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(int a, logic [15:0] x, string n);
    @(posedge SYS_CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a[3:0];
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 chk(n, REG_RDATA, x);
  endtask
  // counter and pin change together so the captured value is unambiguous
  // a match repeats every cycle the counter stays equal, so compares hold it one cycle
  task automatic drive(int n, logic v, logic [15:0] c, int h);
    @(posedge SYS_CLK);
    cnt <= c;
    ext[n] <= v;
    repeat (h) @(posedge SYS_CLK);
  endtask
  task automatic ev(logic [15:0] c, logic [15:0] x);
    @(posedge SYS_CLK);
    cnt <= c;
    evs <= 4'hf;
    #1 chk("cascade gates", {casc0, den}, x);
    @(posedge SYS_CLK);
    evs <= 4'h0;
    repeat (2) @(posedge SYS_CLK);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #500us;
    err_count++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge SYS_CLK);
    RST <= 1'b0;
    wr(7, 16'h00ff);
    for (int a = 0; a < 11; a++) rd(a, 16'h0000, "reset value");
    $display("test reset done");
    wr(tccpc_pkg::ADDR_INT_MASK, 16'h003f);
    for (int n = 0; n < 3; n++) begin
      for (int c = 0; c < 8; c++) begin
        b = (c % 4) != 0;
        o = c / 4;
        wr(tccpc_pkg::ADDR_CH1_REG_B + n, 16'h0010);
        wr(tccpc_pkg::ADDR_CH1_IOCTL + n, 16'(c << 4));
        rd(tccpc_pkg::ADDR_PIN_STATE, 16'((b << (n + 3)) | (o << n)), "initial pin");
        drive(n, 1'b0, 16'h0010, 1);
        cnt <= 16'h0000;
        o = (c % 4 == 1) ? 0 : (c % 4 == 2) ? 1 : (c % 4 == 3) ? 1 - o : o;
        rd(tccpc_pkg::ADDR_PIN_STATE, 16'((b << (n + 3)) | (o << n)), "pin after match");
        chk("pin ports", 16'({poe, pout}), 16'((b << (n + 3)) | (o << n)));
        chk("irq", 16'(IRQ), 16'(b));
        rd(tccpc_pkg::ADDR_INT_STATUS, 16'(b << n), "compare status");
        wr(tccpc_pkg::ADDR_INT_STATUS, 16'h003f);
        #1 chk("irq cleared", 16'(IRQ), 16'h0000);
      end
      wr(tccpc_pkg::ADDR_CH1_IOCTL + n, 16'h0000);
    end
    $display("test compare done");
    wr(tccpc_pkg::ADDR_INT_MASK, 16'h0000);
    for (int n = 0; n < 3; n++) begin
      for (int c = 8; c < 11; c++) begin
        // channel 2 runs with bit 6 set, which it must ignore
        f = (n == 1) ? c + 4 : c;
        wr(tccpc_pkg::ADDR_CH1_REG_B + n, 16'h0000);
        wr(tccpc_pkg::ADDR_CH1_IOCTL + n, 16'(f << 4));
        drive(n, 1'b1, 16'h0100 + 16'(c), 6);
        e = (c != 9) ? 16'h0100 + 16'(c) : 16'h0000;
        rd(tccpc_pkg::ADDR_CH1_REG_B + n, e, "rise capture");
        drive(n, 1'b0, 16'h0200 + 16'(c), 6);
        e = (c != 8) ? 16'h0200 + 16'(c) : e;
        rd(tccpc_pkg::ADDR_CH1_REG_B + n, e, "fall capture");
        chk("masked irq", 16'(IRQ), 16'h0000);
        rd(tccpc_pkg::ADDR_INT_STATUS, 16'(8 << n), "capture status");
        wr(tccpc_pkg::ADDR_INT_STATUS, 16'h003f);
      end
    end
    $display("test capture done");
    wr(tccpc_pkg::ADDR_CASC_CTRL, 16'h0012);
    wr(tccpc_pkg::ADDR_CH1_IOCTL, 16'h00c0);
    wr(tccpc_pkg::ADDR_CH3_IOCTL, 16'h00c0);
    ev(16'h0abc, 16'h0003);
    rd(tccpc_pkg::ADDR_CH1_REG_B, 16'h0abc, "register c capture");
    rd(tccpc_pkg::ADDR_CH3_REG_B, 16'h0abc, "count capture");
    wr(tccpc_pkg::ADDR_CASC_CTRL, 16'h0001);
    ev(16'h0def, 16'h0000);
    rd(tccpc_pkg::ADDR_CH3_REG_B, 16'h0abc, "undivided count");
    $display("test cascade done");
    final_report();
  end
endmodule
